// [pkg/usmc_pkg.sv]
// Purpose: constants and types for the usart mode configuration block
// Assumes: apb with 32-bit data, one word per register
// Notes:   offsets of the registers are chosen locally
package usmc_pkg;

  // register byte offsets
  localparam logic [11:0] CFG_OFF    = 12'h000;
  localparam logic [11:0] TXDATA_OFF = 12'h004;
  localparam logic [11:0] RXDATA_OFF = 12'h008;
  localparam logic [11:0] ADDR_OFF   = 12'h00C;
  localparam logic [11:0] STAT_OFF   = 12'h010;
  localparam logic [11:0] BRG_OFF    = 12'h014;

  // configuration field positions
  localparam int CTS_GATE_BIT   = 9;
  localparam int SYNC_SEL_BIT   = 11;
  localparam int EDGE_SEL_BIT   = 12;
  localparam int MASTER_SEL_BIT = 14;
  localparam int LOOP_BIT       = 15;
  localparam int IR_SEL_BIT     = 16;
  localparam int TA_HOLD_BIT    = 18;
  localparam int HW_MATCH_BIT   = 19;
  localparam int OE_SEL_BIT     = 20;
  localparam int OE_POL_BIT     = 21;
  localparam int ADDR_DET_BIT   = 22;

  // writable bits of the configuration word; reserved bits 13 and 17 stay zero
  localparam logic [31:0] CFG_MASK  = 32'h007DDA00;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [15:0] BRG_RESET = 16'h0007;
  localparam logic [7:0]  ADDR_RESET = 8'h00;

  // character frame: start, 8 data, address/9th bit, stop
  localparam int FRAME_BITS = 11;
  // irda pulse is 3/16 of a bit
  localparam int IR_NUM = 3;
  localparam int IR_DEN = 16;

  // decoded mode bits
  typedef struct packed {
    logic cts_gate;
    logic sync_sel;
    logic edge_sel;
    logic master_sel;
    logic loopback;
    logic ir_sel;
    logic ta_hold;
    logic hw_match;
    logic oe_sel;
    logic oe_pol;
    logic addr_det;
  } usmc_mode_type;

  // one received character
  typedef struct packed {
    logic       addr_flag;
    logic [7:0] data;
  } usmc_char_type;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_SHIFT = 4'h2,
    TX_HOLD  = 4'h4,
    TX_WAIT  = 4'h8
  } usmc_tx_state_type;

endpackage : usmc_pkg

// [src/usmc_sync2.sv]
// Purpose: two flip-flop synchroniser for pins entering the pclk domain
// Assumes: input is a level from outside the clock's domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module usmc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // plain two-stage capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : usmc_sync2

// [src/usmc_top.sv]
// Purpose: usart core with the mode configuration fields over apb
// Assumes: pclk 125 MHz; serial clock slow enough to be oversampled
// Notes:   rxd, cts and slave serial clock pass two flops before use
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - bit 11 picks async or sync framing
// - bit 12 picks receive sampling edge
// - bit 14 picks slave or master role
// - loopback feeds transmit into receiver
// - loopback still drives tx and rts pins
// - loopback routes rts into cts gating
// - bit 16 selects irda line form
// - no hold drops enable after stop
// - hold keeps enable one character more
// - new transmission during hold keeps enable
// - no hardware match leaves addressing to software
// - hardware match with bit 22 address detect compares against address register
// - cts gate pauses transmission between characters
// - oe select turns rts into driver enable
module usmc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             request_to_send_pin,
  input  wire logic        clear_to_send_pin,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe
);
  logic [31:0] cfg_r;
  logic [15:0] brg_r;
  logic [7:0]  addr_r;
  usmc_pkg::usmc_mode_type mode;
  logic rx_s, cts_s, sclk_s;
  logic sclk_d_r;

  assign mode.cts_gate   = cfg_r[usmc_pkg::CTS_GATE_BIT];
  assign mode.sync_sel   = cfg_r[usmc_pkg::SYNC_SEL_BIT];
  assign mode.edge_sel   = cfg_r[usmc_pkg::EDGE_SEL_BIT];
  assign mode.master_sel = cfg_r[usmc_pkg::MASTER_SEL_BIT];
  assign mode.loopback   = cfg_r[usmc_pkg::LOOP_BIT];
  assign mode.ir_sel     = cfg_r[usmc_pkg::IR_SEL_BIT];
  assign mode.ta_hold    = cfg_r[usmc_pkg::TA_HOLD_BIT];
  assign mode.hw_match   = cfg_r[usmc_pkg::HW_MATCH_BIT];
  assign mode.oe_sel     = cfg_r[usmc_pkg::OE_SEL_BIT];
  assign mode.oe_pol     = cfg_r[usmc_pkg::OE_POL_BIT];
  assign mode.addr_det   = cfg_r[usmc_pkg::ADDR_DET_BIT];

  // pin inputs cross into pclk
  usmc_sync2 #(.RST_VAL(1'b1)) u_rx   (.pclk(pclk), .presetn(presetn), .d(serial_rx_pin),
                                        .q(rx_s));
  usmc_sync2 #(.RST_VAL(1'b1)) u_cts  (.pclk(pclk), .presetn(presetn), .d(clear_to_send_pin),
                                        .q(cts_s));
  usmc_sync2 #(.RST_VAL(1'b0)) u_sclk (.pclk(pclk), .presetn(presetn), .d(sclk_in),
                                        .q(sclk_s));

  // ---- bit timing -----------------------------------------------------
  logic [15:0] brg_cnt_r;
  logic        tick;      // one bit period elapsed (async / master)
  logic        mclk_r;    // master serial clock level
  logic        sclk_rise, sclk_fall;
  logic        clk_lvl;

  // baud divider: one tick each brg_r+1 pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_r <= 16'h0000;
    end else if (brg_cnt_r >= brg_r) begin
      brg_cnt_r <= 16'h0000;
    end else begin
      brg_cnt_r <= brg_cnt_r + 16'h0001;
    end
  end
  assign tick = (brg_cnt_r >= brg_r);

  // master clock gen
  // master toggles its clock at half bit points so both edges exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_r <= 1'b0;
    end else if (brg_cnt_r == {1'b0, brg_r[15:1]} || tick) begin
      mclk_r <= ~mclk_r;
    end
  end

  assign clk_lvl = mode.master_sel ? mclk_r : sclk_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= clk_lvl;
    end
  end
  assign sclk_rise = clk_lvl & ~sclk_d_r;
  assign sclk_fall = ~clk_lvl & sclk_d_r;

  logic rx_strobe, tx_strobe;
  assign rx_strobe = mode.sync_sel ? (mode.edge_sel ? sclk_rise : sclk_fall) : tick;
  // transmit changes on the opposite edge so data is stable at sampling
  assign tx_strobe = mode.sync_sel ? (mode.edge_sel ? sclk_fall : sclk_rise) : tick;

  // ---- transmitter ----------------------------------------------------
  usmc_pkg::usmc_tx_state_type tx_state_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  logic [3:0]  hold_cnt_r;
  logic [8:0]  tx_buf_r;
  logic        tx_buf_full_r;
  logic        tx_line;
  logic        rts_flow_r;   // receiver ready to accept
  logic        cts_eff;
  logic        oe_active;

  assign cts_eff = mode.loopback ? rts_flow_r : ~cts_s;  // pin cts is active low

  // transmit state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= usmc_pkg::TX_IDLE;
      tx_sh_r    <= 11'h7FF;
      tx_cnt_r   <= 4'h0;
      hold_cnt_r <= 4'h0;
    end else begin
      case (tx_state_r)
        usmc_pkg::TX_IDLE, usmc_pkg::TX_HOLD: begin
          if (tx_buf_full_r && (!mode.cts_gate || cts_eff) && tx_strobe) begin
            tx_sh_r    <= {1'b1, tx_buf_r, 1'b0};
            tx_cnt_r   <= 4'(usmc_pkg::FRAME_BITS - 1);
            tx_state_r <= usmc_pkg::TX_SHIFT;
          end else if (tx_state_r == usmc_pkg::TX_HOLD && tick) begin
            if (hold_cnt_r == 4'h0) begin
              tx_state_r <= usmc_pkg::TX_IDLE;
            end else begin
              hold_cnt_r <= hold_cnt_r - 4'h1;
            end
          end
        end
        usmc_pkg::TX_SHIFT: begin
          if (tx_strobe) begin
            if (tx_cnt_r == 4'h0) begin
              tx_sh_r <= 11'h7FF;
              hold_cnt_r <= 4'(usmc_pkg::FRAME_BITS - 1);
              tx_state_r <= mode.ta_hold ? usmc_pkg::TX_HOLD : usmc_pkg::TX_IDLE;
            end else begin
              tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
              tx_cnt_r <= tx_cnt_r - 4'h1;
            end
          end
        end
        default: tx_state_r <= usmc_pkg::TX_IDLE;
      endcase
    end
  end
  assign tx_line   = tx_sh_r[0];
  assign oe_active = (tx_state_r == usmc_pkg::TX_SHIFT) || (tx_state_r == usmc_pkg::TX_HOLD);

  // ---- irda encode ----------------------------------------------------
  logic [15:0] ir_cnt_r;
  logic        ir_pulse;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_cnt_r <= 16'h0000;
    end else if (tick) begin
      ir_cnt_r <= 16'h0000;
    end else begin
      ir_cnt_r <= ir_cnt_r + 16'h0001;
    end
  end
  // pulse covers the first 3/16 of each zero bit
  assign ir_pulse = ~tx_line &&
                    (20'(ir_cnt_r) * 20'(usmc_pkg::IR_DEN) < 20'(brg_r) * 20'(usmc_pkg::IR_NUM));

  // ---- receiver -------------------------------------------------------
  logic       rx_in;
  logic       rx_bit;
  logic [9:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic       rx_busy_r;
  logic [8:0] rx_buf_r;
  logic       rx_full_r;
  logic       match_ok;

  assign rx_in  = mode.loopback ? tx_line : rx_s;
  assign rx_bit = (mode.ir_sel && !mode.loopback) ? ~rx_in : rx_in;

  assign match_ok = !mode.addr_det || !mode.hw_match || !rx_sh_r[9]
                    || (rx_sh_r[8:1] == addr_r);

  // receive shift: start at a low bit, take data, store on stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_r   <= 10'h000;
      rx_cnt_r  <= 4'h0;
      rx_busy_r <= 1'b0;
      rx_buf_r  <= 9'h000;
      rx_full_r <= 1'b0;
    end else begin
      if (rx_strobe) begin
        if (!rx_busy_r) begin
          if (!rx_bit) begin
            rx_busy_r <= 1'b1;
            rx_cnt_r  <= 4'(usmc_pkg::FRAME_BITS - 1);
          end
        end else if (rx_cnt_r == 4'h1) begin
          rx_busy_r <= 1'b0;
          rx_cnt_r  <= 4'h0;
          if (match_ok) begin
            rx_buf_r  <= rx_sh_r[9:1];
            rx_full_r <= 1'b1;
          end
        end else begin
          rx_sh_r  <= {rx_bit, rx_sh_r[9:1]};
          rx_cnt_r <= rx_cnt_r - 4'h1;
        end
      end
      // reading data frees the buffer; a new store in that cycle wins
      if (psel && penable && !pready && !pwrite && paddr == usmc_pkg::RXDATA_OFF
          && !(rx_strobe && rx_busy_r && rx_cnt_r == 4'h1 && match_ok)) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // receiver asks for more data while its buffer is empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_flow_r <= 1'b0;
    end else begin
      rts_flow_r <= ~rx_full_r;
    end
  end

  // ---- apb slave ------------------------------------------------------
  logic acc;
  assign acc = psel && penable && !pready;

  // single wait state: pready pulses in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        if (paddr == usmc_pkg::CFG_OFF) begin
          prdata <= cfg_r;
        end else if (paddr == usmc_pkg::RXDATA_OFF) begin
          prdata <= {23'h000000, rx_buf_r};
        end else if (paddr == usmc_pkg::ADDR_OFF) begin
          prdata <= {24'h000000, addr_r};
        end else if (paddr == usmc_pkg::STAT_OFF) begin
          prdata <= {27'h0000000, oe_active, rx_busy_r, ~tx_buf_full_r,
                     tx_state_r == usmc_pkg::TX_IDLE, rx_full_r};
        end else if (paddr == usmc_pkg::BRG_OFF) begin
          prdata <= {16'h0000, brg_r};
        end else if (paddr == usmc_pkg::TXDATA_OFF) begin
          prdata <= 32'h00000000;
        end else begin
          prdata  <= 32'h00000000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // register writes land in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r  <= usmc_pkg::CFG_RESET;
      brg_r  <= usmc_pkg::BRG_RESET;
      addr_r <= usmc_pkg::ADDR_RESET;
    end else if (acc && pwrite) begin
      if (paddr == usmc_pkg::CFG_OFF) begin
        cfg_r <= pwdata & usmc_pkg::CFG_MASK;
      end else if (paddr == usmc_pkg::BRG_OFF) begin
        brg_r <= pwdata[15:0];
      end else if (paddr == usmc_pkg::ADDR_OFF) begin
        addr_r <= pwdata[7:0];
      end
    end
  end

  // transmit holding word; a write while full is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r      <= 9'h000;
      tx_buf_full_r <= 1'b0;
    end else if (acc && pwrite && paddr == usmc_pkg::TXDATA_OFF && !tx_buf_full_r) begin
      tx_buf_r      <= pwdata[8:0];
      tx_buf_full_r <= 1'b1;
    end else if ((tx_state_r == usmc_pkg::TX_IDLE || tx_state_r == usmc_pkg::TX_HOLD)
                 && tx_buf_full_r && (!mode.cts_gate || cts_eff) && tx_strobe) begin
      tx_buf_full_r <= 1'b0;
    end
  end

  // ---- pins -----------------------------------------------------------
  // all outputs registered to avoid glitches on the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_pin       <= 1'b1;
      request_to_send_pin <= 1'b1;
      sclk_out            <= 1'b0;
      sclk_oe             <= 1'b0;
    end else begin
      serial_tx_pin <= mode.ir_sel ? ir_pulse : tx_line;
      request_to_send_pin <= mode.oe_sel ? (oe_active ~^ mode.oe_pol) : ~rts_flow_r;
      sclk_out <= mclk_r;
      sclk_oe  <= mode.sync_sel && mode.master_sel;
    end
  end

endmodule : usmc_top

// [bench/usmc_monitor.sv]
// Purpose: port checker for usmc_top
// Assumes: apb answers one cycle into the access phase
// Notes:   keeps a shadow of the last configuration write
`timescale 1ns/1ps
module usmc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_tx_pin,
  input wire logic        request_to_send_pin,
  input wire logic        sclk_oe
);
  logic [31:0] cfg_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow word, taken at the same edge as the design takes the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 32'h00000000;
    end else if (psel && penable && !pready && pwrite && paddr == usmc_pkg::CFG_OFF) begin
      cfg_r <= pwdata;
    end
  end
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_cfg_read;
    s_taken ##0 (!pwrite && paddr == usmc_pkg::CFG_OFF);
  endsequence
  property p_ready_answer;
    s_taken |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_unmapped;
    s_taken ##0 (paddr > usmc_pkg::BRG_OFF) |=> pslverr;
  endproperty
  property p_mapped;
    s_taken ##0 (paddr == usmc_pkg::CFG_OFF) |=> !pslverr;
  endproperty
  property p_cfg_read;
    s_cfg_read |=> prdata == (cfg_r & usmc_pkg::CFG_MASK);
  endproperty
  property p_master_oe;
    (cfg_r[11] && cfg_r[14])[*3] |-> sclk_oe;
  endproperty
  property p_slave_oe;
    (!(cfg_r[11] && cfg_r[14]))[*3] |-> !sclk_oe;
  endproperty
  property p_oe_drive;
    (cfg_r[20] && cfg_r[21] && !cfg_r[16] && !serial_tx_pin)[*2] |-> request_to_send_pin;
  endproperty
  a_ready_answer: assert property (p_ready_answer)
    else $error("no pready after access");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without pslverr");
  a_mapped: assert property (p_mapped)
    else $error("pslverr on configuration access");
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration readback wrong");
  a_master_oe: assert property (p_master_oe)
    else $error("master without clock drive");
  a_slave_oe: assert property (p_slave_oe)
    else $error("clock driven outside master role");
  a_oe_drive: assert property (p_oe_drive)
    else $error("driver enable off while sending");
endmodule : usmc_monitor

bind usmc_top usmc_monitor usmc_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_tx_pin(serial_tx_pin),
  .request_to_send_pin(request_to_send_pin), .sclk_oe(sclk_oe));

// [bench/usmc_partner.sv]
// Purpose: remote serial device facing the usart pins
// Assumes: echoes what it hears straight back
// Notes:   mute holds the line at idle to expose an internal path
`timescale 1ns/1ps
module usmc_partner (
  input  wire logic tx,
  input  wire logic mute,
  input  wire logic stall,
  input  wire logic sclk_run,
  output logic      rx,
  output logic      cts_n,
  output logic      sclk
);
  // remote clock supply; still while not running
  initial sclk = 1'b0;
  always #32 sclk = sclk_run ? ~sclk : 1'b0;
  // echo path, held idle high when muted so no false start bit appears
  assign rx = mute ? 1'b1 : tx;
  assign cts_n = stall;
endmodule : usmc_partner

// [bench/testbench.sv]
// Purpose: self-checking bench for usmc_top
// Assumes: bit time of brg+1 clocks, brg set to 3
// Notes:   the partner echoes serial data back
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", n, e, g); error_cnt++; end end
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, serial_rx_pin, serial_tx_pin, request_to_send_pin;
  logic        clear_to_send_pin, sclk_in, sclk_out, sclk_oe;
  logic        mute = 1'b0, stall = 1'b0, sclk_run = 1'b0, tx_low = 1'b0, rts_drop = 1'b0;
  int          error_cnt = 0, samples_checked = 0;
  always #4 pclk = ~pclk;
  usmc_top usmc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .request_to_send_pin(request_to_send_pin), .clear_to_send_pin(clear_to_send_pin),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe));
  usmc_partner usmc_partner_i (.tx(serial_tx_pin), .mute(mute), .stall(stall),
    .sclk_run(sclk_run), .rx(serial_rx_pin), .cts_n(clear_to_send_pin), .sclk(sclk_in));
  // line activity flags, sampled mid-cycle away from the launching edge
  always @(negedge pclk) begin
    if (serial_tx_pin === 1'b0) tx_low = 1'b1;
    if (request_to_send_pin !== 1'b1) rts_drop = 1'b1;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is seen at a rising edge; reply taken there
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic check_rx(input logic [8:0] d, input logic exp_rx);
    logic [31:0] r;
    logic        e, got;
    got = 1'b0;
    for (int i = 0; i < 80 && !got; i++) begin
      apb(1'b0, usmc_pkg::STAT_OFF, 32'h0, r, e);
      got = r[0];
    end
    `CHK("rx full", exp_rx, got)
    if (got) begin
      apb(1'b0, usmc_pkg::RXDATA_OFF, 32'h0, r, e);
      `CHK("rx data", d[7:0], r[7:0])
    end
  endtask : check_rx
  task automatic xfer(input logic [31:0] cfg, input logic [8:0] d, input logic exp_rx);
    logic [31:0] r;
    logic        e;
    apb(1'b1, usmc_pkg::CFG_OFF, cfg, r, e);
    apb(1'b1, usmc_pkg::TXDATA_OFF, {23'h0, d}, r, e);
    check_rx(d, exp_rx);
  endtask : xfer
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, usmc_pkg::CFG_OFF, 32'h0, r, e);
    `CHK("cfg reset", usmc_pkg::CFG_RESET, r)
    apb(1'b0, usmc_pkg::BRG_OFF, 32'h0, r, e);
    `CHK("brg reset", {16'h0000, usmc_pkg::BRG_RESET}, r)
    apb(1'b1, usmc_pkg::CFG_OFF, 32'hFFFFFFFF, r, e);
    apb(1'b0, usmc_pkg::CFG_OFF, 32'h0, r, e);
    `CHK("cfg mask", usmc_pkg::CFG_MASK, r)
    apb(1'b0, 12'h018, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    apb(1'b1, usmc_pkg::CFG_OFF, 32'h00004800, r, e);
    repeat (4) @(posedge pclk);
    `CHK("master clock drive", 1'b1, sclk_oe)
    apb(1'b1, usmc_pkg::CFG_OFF, 32'h00010000, r, e);
    repeat (4) @(posedge pclk);
    `CHK("irda idle level", 1'b0, serial_tx_pin)
    // leaving irda lets the echoed low line pose as a start bit; flush it
    apb(1'b1, usmc_pkg::CFG_OFF, 32'h00000000, r, e);
    repeat (120) @(posedge pclk);
    apb(1'b0, usmc_pkg::RXDATA_OFF, 32'h0, r, e);
    apb(1'b1, usmc_pkg::BRG_OFF, 32'h00000003, r, e);
    apb(1'b1, usmc_pkg::ADDR_OFF, 32'h0000005A, r, e);
  endtask : t_regs
  task automatic t_cts();
    logic [31:0] r;
    logic        e;
    stall <= 1'b1;
    apb(1'b1, usmc_pkg::CFG_OFF, 32'h00000200, r, e);
    tx_low = 1'b0;
    apb(1'b1, usmc_pkg::TXDATA_OFF, 32'h000000C3, r, e);
    repeat (100) @(posedge pclk);
    `CHK("gated line quiet", 1'b0, tx_low)
    stall <= 1'b0;
    check_rx(9'h0C3, 1'b1);
  endtask : t_cts
  task automatic t_loop_cts();
    logic [31:0] r;
    logic        e;
    // full receive buffer drops the looped request, so the next word waits
    apb(1'b1, usmc_pkg::CFG_OFF, 32'h00008200, r, e);
    apb(1'b1, usmc_pkg::TXDATA_OFF, 32'h00000047, r, e);
    repeat (60) @(posedge pclk);
    apb(1'b1, usmc_pkg::TXDATA_OFF, 32'h00000074, r, e);
    repeat (100) @(posedge pclk);
    apb(1'b0, usmc_pkg::STAT_OFF, 32'h0, r, e);
    `CHK("looped rts holds tx", 2'b01, {r[2], r[0]})
    check_rx(9'h047, 1'b1);
    check_rx(9'h074, 1'b1);
  endtask : t_loop_cts
  task automatic t_oe();
    logic [31:0] r;
    logic        e;
    xfer(32'h00308000, 9'h011, 1'b1);
    repeat (12) @(posedge pclk);
    `CHK("enable dropped", 1'b0, request_to_send_pin)
    xfer(32'h00348000, 9'h022, 1'b1);
    rts_drop = 1'b0;
    apb(1'b1, usmc_pkg::TXDATA_OFF, 32'h00000033, r, e);
    check_rx(9'h033, 1'b1);
    `CHK("enable unbroken", 1'b0, rts_drop)
    `CHK("enable in hold", 1'b1, request_to_send_pin)
    repeat (70) @(posedge pclk);
    `CHK("enable after hold", 1'b0, request_to_send_pin)
  endtask : t_oe
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // watchdog, well beyond the few thousand cycles the tests take
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    xfer(32'h00000000, 9'h0A5, 1'b1);
    mute <= 1'b1;
    tx_low = 1'b0;
    xfer(32'h00008000, 9'h03C, 1'b1);
    `CHK("tx pin in loopback", 1'b1, tx_low)
    mute <= 1'b0;
    sclk_run <= 1'b1;
    xfer(32'h00000800, 9'h069, 1'b1);
    xfer(32'h00001800, 9'h096, 1'b1);
    sclk_run <= 1'b0;
    t_cts();
    t_loop_cts();
    xfer(32'h00488000, 9'h15A, 1'b1);
    xfer(32'h00488000, 9'h133, 1'b0);
    xfer(32'h00408000, 9'h133, 1'b1);
    xfer(32'h0000C800, 9'h0E1, 1'b1);
    t_oe();
    close_out();
  end
endmodule : testbench
